//--- core/eps_map.svh
// register map, field positions, reset values and timing counts of the
// eeprom program/erase sequencer; included by the package only, the core uses its macros
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH

// ********************************************************************
// register indices (byte address on the bus is four times the index)
// ********************************************************************
`define EPS_ARRAY_BASE 16'h0800
`define EPS_ARRAY_LAST 16'h09ff
`define EPS_SECURE_FIRST 16'h08f0
`define EPS_SECURE_LAST 16'h08ff
`define EPS_DIV_OPT_HIGH 16'hfe10
`define EPS_DIV_OPT_LOW 16'hfe11
`define EPS_DIVISOR_HIGH 16'hfe1a
`define EPS_DIVISOR_LOW 16'hfe1b
`define EPS_NV_CONFIG 16'hfe1c
`define EPS_NVM_CONTROL 16'hfe1d
`define EPS_ARRAY_CONFIG 16'hfe1f

// ********************************************************************
// field positions
// ********************************************************************
`define EPS_CFG_SECURITY_BIT 4
`define EPS_DIV_LOCK_DIS_BIT 7

// ********************************************************************
// reset and factory values
// ********************************************************************
`define EPS_NV_FACTORY 8'h10
`define EPS_ERASED_BYTE 8'hff
`define EPS_CTRL_RESET 8'h00

// ********************************************************************
// timing: timebase period and cycle lengths in timebase periods
// ********************************************************************
`define EPS_TIMEBASE_NS 35000
`define EPS_CLK_NS 40
`define EPS_DIV_DEFAULT (11'((`EPS_TIMEBASE_NS * 10 / `EPS_CLK_NS + 5) / 10))
`define EPS_PROGRAM_PERIODS 12'd100
`define EPS_BYTE_ERASE_PERIODS 12'd100
`define EPS_BLOCK_ERASE_PERIODS 12'd100
`define EPS_BULK_ERASE_PERIODS 12'd100

`endif

//--- core/eps_pkg.sv
// types shared by the eeprom program/erase sequencer
// assumes eps_map.svh is reachable on the include path
package eps_pkg;
`include "eps_map.svh"

   // ********************************************************************
   // operation modes, in the order of the two-bit mode field
   // ********************************************************************
   typedef enum logic [1:0] {
      MODE_PROGRAM,
      MODE_BYTE_ERASE,
      MODE_BLOCK_ERASE,
      MODE_BULK_ERASE
   } eps_mode_e;

   // ********************************************************************
   // control register, msb first as it sits on the data bus
   // ********************************************************************
   typedef struct packed {
      logic dummy;
      logic zero;
      logic powerOff;
      eps_mode_e mode;
      logic latchEnable;
      logic selfTimed;
      logic hvCycleEnable;
   } eps_ctrl_s;

endpackage

//--- core/eps_sequencer.sv
// program/erase sequencer for a 512-byte eeprom array behind classic wishbone
// assumes a single 25 mhz clock, a synchronous active-high reset and a
// crystal reference that arrives as a one-cycle enable pulse on that clock
//
// Operation
// RQ1: array window 0x0800-0x09ff plus nv byte
// RQ2: reset copies nv byte and divider option
// RQ3: timebase is reference clock over divisor
// RQ4: software loads divisor before any cycle
// RQ5: security refuses 0x08f0 through 0x08ff
// RQ6: security disables block and bulk erase
// RQ7: security locks the nv configuration byte
// RQ8: four 128-byte blocks, each protect bit
// RQ9: protect bits refresh on nv byte read
// RQ10: program clears bits, erase sets bits
// RQ11: program one byte, erase byte to array
// RQ12: mode field selects program or erase kind
// RQ13: latch captures valid array writes only
// RQ14: latest valid write replaces earlier capture
// RQ15: latched read returns data, captures address
// RQ16: control writes wait for a capture
// RQ17: enable needs latch and valid capture
// RQ18: mode frozen while enable set
// RQ19: self-timed clears enable at timer end
// RQ20: software times cycle without self-timed
// RQ21: clearing both bits clears enable only
// RQ22: block and bulk erase spare nv byte
// RQ23: cpu wait does not disturb cycle
// RQ24: stop suspends cycle or aborts it
// RQ25: latch cannot clear while enable set
// RQ26: reset clears all control bits
// RQ27: divisor writable only unlatched and unlocked
// RQ28: enable held for mode's timebase count
`timescale 1ns/100ps
module eps_sequencer
   import eps_pkg::*;
#(
   parameter logic [10:0] DIV_OPTION = `EPS_DIV_DEFAULT,
   parameter logic DIV_LOCK_DIS_OPTION = 1'b1,
   parameter logic [11:0] PROGRAM_PERIODS = `EPS_PROGRAM_PERIODS,
   parameter logic [11:0] BYTE_ERASE_PERIODS = `EPS_BYTE_ERASE_PERIODS,
   parameter logic [11:0] BLOCK_ERASE_PERIODS = `EPS_BLOCK_ERASE_PERIODS,
   parameter logic [11:0] BULK_ERASE_PERIODS = `EPS_BULK_ERASE_PERIODS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic nvInit,
   input wire logic crystalTick,
   input wire logic timebaseClockSelect,
   input wire logic securityOption,
   input wire logic stopMode,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic hvActive
);

   // ********************************************************************
   // state
   // ********************************************************************
   typedef struct packed {
      logic ack;
      logic [7:0] readData;
      eps_ctrl_s ctrl;
      logic [7:0] arrayConfig;
      logic [7:0] nvConfig;
      logic divLockDisable;
      logic [10:0] divisor;
      logic [15:0] latchAddr;
      logic [7:0] latchData;
      logic captured;
      logic [10:0] divCount;
      logic [11:0] periodCount;
      logic cycleDone;
      logic stopPrev;
      logic resumeBusy;
      logic hv;
      logic [511:0][7:0] cells;
   } eps_state_s;

   eps_state_s state_reg;
   eps_state_s state_next;

   // ********************************************************************
   // address helpers
   // ********************************************************************
   function automatic logic inArray(input logic [15:0] idx);
      return idx >= `EPS_ARRAY_BASE && idx <= `EPS_ARRAY_LAST;
   endfunction

   // RQ1: the window plus the nv byte are the only targets
   function automatic logic validTarget(input logic [15:0] idx);
      return inArray(idx) || idx == `EPS_NV_CONFIG;
   endfunction

   function automatic logic inSecureRange(input logic [15:0] idx);
      return idx >= `EPS_SECURE_FIRST && idx <= `EPS_SECURE_LAST;
   endfunction

   function automatic logic [8:0] cellIndex(input logic [15:0] idx);
      logic [15:0] off;
      off = idx - `EPS_ARRAY_BASE;
      return off[8:0];
   endfunction

   function automatic logic [11:0] modePeriods(input eps_mode_e m);
      case (m)
         MODE_PROGRAM: return PROGRAM_PERIODS;
         MODE_BYTE_ERASE: return BYTE_ERASE_PERIODS;
         MODE_BLOCK_ERASE: return BLOCK_ERASE_PERIODS;
         default: return BULK_ERASE_PERIODS;
      endcase
   endfunction

   logic request;
   logic writeByte;
   logic [15:0] reqIdx;
   logic [7:0] wrData;
   eps_ctrl_s wrCtrl;
   logic refTick;
   logic secure;
   logic [8:0] tgtCell;
   logic [1:0] tgtBlock;
   logic tgtIsNv;
   logic opAllowed;
   logic arrayBlocked;

   assign request = wb_cyc_i && wb_stb_i && !state_reg.ack;
   assign writeByte = wb_we_i && wb_sel_i[0];
   assign reqIdx = wb_adr_i;
   assign wrData = wb_dat_i[7:0];
   assign wrCtrl = eps_ctrl_s'(wb_dat_i[7:0]);
   // RQ3: bus clock runs every cycle, crystal arrives as a pulse
   assign refTick = timebaseClockSelect ? crystalTick : 1'b1;
   // RQ5: security is live only with the mask option and the bit at zero
   assign secure = securityOption && !state_reg.arrayConfig[`EPS_CFG_SECURITY_BIT];
   assign tgtCell = cellIndex(state_reg.latchAddr);
   assign tgtBlock = tgtCell[8:7];
   assign tgtIsNv = state_reg.latchAddr == `EPS_NV_CONFIG;
   // array access after a stop exit waits for the restarted cycle
   assign arrayBlocked = state_reg.resumeBusy || state_reg.ctrl.powerOff;

   // ********************************************************************
   // protection decision for the latched target
   // ********************************************************************
   always_comb begin
      opAllowed = 1'b1;
      if (secure) begin
         // RQ5: secured range refused
         if (inSecureRange(state_reg.latchAddr)) begin
            opAllowed = 1'b0;
         end
         // RQ7: nv byte locked under security
         if (tgtIsNv) begin
            opAllowed = 1'b0;
         end
         // RQ6: block and bulk erase disabled
         if (state_reg.ctrl.mode == MODE_BLOCK_ERASE || state_reg.ctrl.mode == MODE_BULK_ERASE) begin
            opAllowed = 1'b0;
         end
      end
      // RQ8: protected block refuses everything
      // RQ12: protect bit overrides the mode field
      if (!tgtIsNv && state_reg.arrayConfig[tgtBlock]) begin
         opAllowed = 1'b0;
      end
   end

   // ********************************************************************
   // next state
   // ********************************************************************
   always_comb begin
      state_next = state_reg;
      state_next.ack = request;
      state_next.stopPrev = stopMode;

      // ****************************************************************
      // timebase and cycle timer
      // ****************************************************************
      // RQ23: cpu wait is not seen here, so the cycle keeps running
      if (state_reg.ctrl.hvCycleEnable && !state_reg.cycleDone && !stopMode && refTick) begin
         // RQ3: one timebase period per divisor reference ticks
         if (12'(state_reg.divCount) + 12'd1 >= 12'(state_reg.divisor)) begin
            state_next.divCount = '0;
            // RQ28: count the mode's periods
            if (state_reg.periodCount + 12'd1 >= modePeriods(state_reg.ctrl.mode)) begin
               state_next.periodCount = '0;
               state_next.cycleDone = 1'b1;
               state_next.resumeBusy = 1'b0;
               // RQ19: self-timed release of the enable bit
               if (state_reg.ctrl.selfTimed) begin
                  state_next.ctrl.hvCycleEnable = 1'b0;
                  state_next.cycleDone = 1'b0;
               end
               if (opAllowed) begin
                  case (state_reg.ctrl.mode)
                     // RQ10: program only clears bits
                     // RQ11: program touches one byte
                     MODE_PROGRAM: begin
                        if (tgtIsNv) begin
                           state_next.nvConfig = state_reg.nvConfig & state_reg.latchData;
                        end else begin
                           state_next.cells[tgtCell] = state_reg.cells[tgtCell]
                              & state_reg.latchData;
                        end
                     end
                     // RQ22: of the erase modes only byte erase reaches the nv byte
                     MODE_BYTE_ERASE: begin
                        if (tgtIsNv) begin
                           state_next.nvConfig = `EPS_ERASED_BYTE;
                        end else begin
                           state_next.cells[tgtCell] = `EPS_ERASED_BYTE;
                        end
                     end
                     // RQ11: erase one block of 128 bytes
                     MODE_BLOCK_ERASE: begin
                        for (int i = 0; i < 512; i++) begin
                           if (!tgtIsNv && 2'(i >> 7) == tgtBlock) begin
                              state_next.cells[i] = `EPS_ERASED_BYTE;
                           end
                        end
                     end
                     // RQ11: bulk erase skips protected blocks
                     default: begin
                        for (int i = 0; i < 512; i++) begin
                           if (!tgtIsNv && !state_reg.arrayConfig[2'(i >> 7)]) begin
                              state_next.cells[i] = `EPS_ERASED_BYTE;
                           end
                        end
                     end
                  endcase
               end
            end else begin
               state_next.periodCount = state_reg.periodCount + 12'd1;
            end
         end else begin
            state_next.divCount = state_reg.divCount + 11'd1;
         end
      end

      // ****************************************************************
      // stop mode
      // ****************************************************************
      if (stopMode && !state_reg.stopPrev) begin
         state_next.divCount = '0;
         state_next.periodCount = '0;
         if (state_reg.ctrl.latchEnable && state_reg.ctrl.hvCycleEnable) begin
            // RQ24: suspend, restart from zero after stop
            state_next.resumeBusy = !state_reg.cycleDone;
         end else begin
            // RQ24: any other case ends the cycle abruptly
            state_next.ctrl.hvCycleEnable = 1'b0;
            state_next.cycleDone = 1'b0;
         end
      end

      // ****************************************************************
      // bus access
      // ****************************************************************
      state_next.readData = '0;
      if (request && !wb_we_i) begin
         if (validTarget(reqIdx)) begin
            if (state_reg.ctrl.latchEnable) begin
               // RQ15: latched read returns latched data
               state_next.readData = state_reg.latchData;
               state_next.latchAddr = reqIdx;
            end else if (arrayBlocked) begin
               state_next.readData = `EPS_ERASED_BYTE;
            end else if (reqIdx == `EPS_NV_CONFIG) begin
               state_next.readData = state_reg.nvConfig;
               // RQ9: a read refreshes the live protect bits
               state_next.arrayConfig[3:0] = state_reg.nvConfig[3:0];
            end else begin
               state_next.readData = state_reg.cells[cellIndex(reqIdx)];
            end
         end else if (reqIdx == `EPS_DIV_OPT_HIGH) begin
            state_next.readData = {DIV_LOCK_DIS_OPTION, 4'h0, DIV_OPTION[10:8]};
         end else if (reqIdx == `EPS_DIV_OPT_LOW) begin
            state_next.readData = DIV_OPTION[7:0];
         end else if (reqIdx == `EPS_DIVISOR_HIGH) begin
            state_next.readData = {state_reg.divLockDisable, 4'h0, state_reg.divisor[10:8]};
         end else if (reqIdx == `EPS_DIVISOR_LOW) begin
            state_next.readData = state_reg.divisor[7:0];
         end else if (reqIdx == `EPS_NVM_CONTROL) begin
            state_next.readData = state_reg.ctrl;
         end else if (reqIdx == `EPS_ARRAY_CONFIG) begin
            state_next.readData = state_reg.arrayConfig;
         end
      end

      if (request && writeByte) begin
         if (validTarget(reqIdx)) begin
            // RQ13: capture only while latching
            // RQ14: newest capture replaces older one
            if (state_reg.ctrl.latchEnable && !state_reg.ctrl.hvCycleEnable
                  && !arrayBlocked) begin
               state_next.latchAddr = reqIdx;
               state_next.latchData = wrData;
               state_next.captured = 1'b1;
            end
         end else if (reqIdx == `EPS_DIVISOR_HIGH || reqIdx == `EPS_DIVISOR_LOW) begin
            // RQ27: divisor locked while latched or while the lock-disable bit is clear
            if (!state_reg.ctrl.latchEnable && state_reg.divLockDisable) begin
               if (reqIdx == `EPS_DIVISOR_HIGH) begin
                  state_next.divLockDisable = wrData[`EPS_DIV_LOCK_DIS_BIT];
                  state_next.divisor[10:8] = wrData[2:0];
               end else begin
                  state_next.divisor[7:0] = wrData;
               end
            end
         end else if (reqIdx == `EPS_NVM_CONTROL) begin
            // RQ16: while latched, control waits for a capture
            if (!state_reg.ctrl.latchEnable || state_reg.captured) begin
               state_next.ctrl.dummy = wrCtrl.dummy;
               state_next.ctrl.powerOff = wrCtrl.powerOff;
               state_next.ctrl.selfTimed = wrCtrl.selfTimed;
               // RQ18: mode frozen while enable set
               if (!state_reg.ctrl.hvCycleEnable) begin
                  state_next.ctrl.mode = wrCtrl.mode;
               end
               // RQ25: enable holds the latch
               // RQ21: clearing both clears only enable
               if (!state_reg.ctrl.hvCycleEnable) begin
                  state_next.ctrl.latchEnable = wrCtrl.latchEnable;
                  if (wrCtrl.latchEnable && !state_reg.ctrl.latchEnable) begin
                     state_next.captured = 1'b0;
                  end
               end
               if (!wrCtrl.hvCycleEnable) begin
                  state_next.ctrl.hvCycleEnable = 1'b0;
                  state_next.cycleDone = 1'b0;
                  state_next.divCount = '0;
                  state_next.periodCount = '0;
                  state_next.resumeBusy = 1'b0;
               end else if (!state_reg.ctrl.hvCycleEnable) begin
                  // RQ17: enable needs latch and valid capture
                  if (state_reg.ctrl.latchEnable && state_reg.captured
                        && validTarget(state_reg.latchAddr)) begin
                     state_next.ctrl.hvCycleEnable = 1'b1;
                     state_next.cycleDone = 1'b0;
                     state_next.divCount = '0;
                     state_next.periodCount = '0;
                  end
               end
            end
         end
      end

      // the pump runs only while a cycle is live and the cpu is not stopped
      state_next.hv = state_next.ctrl.hvCycleEnable && !state_next.cycleDone && !stopMode;

      // ****************************************************************
      // reset
      // ****************************************************************
      if (reset) begin
         // nv cells keep their contents unless a power-on fill is asked for
         if (nvInit) begin
            state_next.nvConfig = `EPS_NV_FACTORY;
            for (int i = 0; i < 512; i++) begin
               state_next.cells[i] = `EPS_ERASED_BYTE;
            end
         end
         state_next.ack = 1'b0;
         state_next.readData = '0;
         // RQ26: every control bit cleared
         state_next.ctrl = eps_ctrl_s'(`EPS_CTRL_RESET);
         // RQ2: configuration reloaded from its sources
         state_next.arrayConfig = nvInit ? `EPS_NV_FACTORY : state_reg.nvConfig;
         state_next.divisor = DIV_OPTION;
         state_next.divLockDisable = DIV_LOCK_DIS_OPTION;
         state_next.latchAddr = '0;
         state_next.latchData = '0;
         state_next.captured = 1'b0;
         state_next.divCount = '0;
         state_next.periodCount = '0;
         state_next.cycleDone = 1'b0;
         state_next.stopPrev = 1'b0;
         state_next.resumeBusy = 1'b0;
         state_next.hv = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   assign wb_ack_o = state_reg.ack;
   assign wb_dat_o = {24'h000000, state_reg.readData};
   assign hvActive = state_reg.hv;

endmodule

//--- verification/eps_cpu_model.sv
// processor-side model issuing classic single wishbone cycles
// assumes a registered ack; only the low byte lane carries data
`timescale 1ns/100ps
module eps_cpu_model (
   input wire logic clk,
   input wire logic ack,
   input wire logic [31:0] datR,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [15:0] adr,
   output logic [3:0] sel,
   output logic [31:0] datW
);
   // ************************
   // bus cycle
   // ************************
   initial begin
      {cyc, stb, we, sel} = 7'h00;
      adr = 16'h0000;
      datW = 32'h0;
   end
   // released address and data lines show the inverse so a stale value never looks valid
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk);
      {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
      adr <= a;
      datW <= {24'h0, d};
      // no limit of its own: a hung answer is ended by the bench watchdog
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = datR[7:0];
      {cyc, stb, we, sel} <= 7'h00;
      adr <= ~a;
      datW <= ~{24'h0, d};
   endtask
endmodule

//--- verification/eps_sequencer_asserts.sv
// checker for the sequencer bus answer and high-voltage output
// bound to eps_sequencer; sees only its ports
`timescale 1ns/100ps
module eps_sequencer_asserts #(
   parameter logic [10:0] DIV_OPTION = 11'h36b
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic stopMode,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:2] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic hvActive
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);
   // ************************
   // bus answer and high voltage
   // ************************
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside an answer");
   a_unmapped_zero: assert property (wb_ack_o && wb_adr_i == 16'hfe1e |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_option_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'hfe11
      |-> wb_dat_o[7:0] == DIV_OPTION[7:0]) else $error("divider option low wrong");
   a_reset_quiet: assert property ($fell(reset) |-> !wb_ack_o && !hvActive)
      else $error("outputs busy after reset");
   // the short period counts used here keep a whole cycle well inside sixteen clocks
   a_hv_bounded: assert property ($rose(hvActive) |-> ##[1:16] !hvActive)
      else $error("high voltage held too long");
   a_stop_hv_off: assert property (stopMode && $past(stopMode) |-> !hvActive)
      else $error("high voltage during stop");
endmodule
bind eps_sequencer eps_sequencer_asserts #(.DIV_OPTION(DIV_OPTION)) eps_sequencer_asserts_inst (
   .clk(clk), .reset(reset), .stopMode(stopMode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .hvActive(hvActive));

//--- verification/tb_top.sv
// self-checking bench for the eeprom program/erase sequencer
// assumes the cpu model and the bound checker are compiled beside it
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic w;
      logic [15:0] a;
      logic [7:0] d;
   } eps_row_s;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic nvInit = 1'b1;
   logic stopMode = 1'b0;
   logic crystalTick = 1'b0;
   logic timebaseClockSelect = 1'b0;
   logic securityOption = 1'b1;
   logic cyc, stb, we, ack, hvActive;
   logic [15:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR;
   int errTotal = 0;
   int compares = 0;
   // a read row holds the expected byte in d
   eps_row_s rows [13] = '{'{1'b0, 16'hfe1d, 8'h00}, '{1'b0, 16'hfe1a, 8'h80},
      '{1'b0, 16'hfe1b, 8'h03}, '{1'b0, 16'hfe11, 8'h03}, '{1'b0, 16'hfe1f, 8'h10},
      '{1'b0, 16'hfe1c, 8'h10}, '{1'b0, 16'h0800, 8'hff}, '{1'b0, 16'hfe1e, 8'h00},
      '{1'b1, 16'hfe1b, 8'h05}, '{1'b0, 16'hfe1b, 8'h05}, '{1'b1, 16'hfe1b, 8'h03},
      '{1'b1, 16'h0800, 8'h00}, '{1'b0, 16'h0800, 8'hff}};
   always #20 clk = ~clk;
   // crystal reference as an every-other-cycle enable, ignored until selected
   always @(posedge clk) crystalTick <= ~crystalTick;
   eps_sequencer #(.DIV_OPTION(11'h003), .PROGRAM_PERIODS(12'h002),
      .BYTE_ERASE_PERIODS(12'h002), .BLOCK_ERASE_PERIODS(12'h002),
      .BULK_ERASE_PERIODS(12'h002)) eps_sequencer_inst (.clk(clk), .reset(reset),
      .nvInit(nvInit), .crystalTick(crystalTick), .timebaseClockSelect(timebaseClockSelect),
      .securityOption(securityOption),
      .stopMode(stopMode), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .hvActive(hvActive));
   eps_cpu_model eps_cpu_model_inst (.clk(clk), .ack(ack), .datR(datR), .cyc(cyc), .stb(stb),
      .we(we), .adr(adr), .sel(sel), .datW(datW));
   // ************************
   // helpers
   // ************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errTotal++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      eps_cpu_model_inst.acc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      eps_cpu_model_inst.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   // poll control only, never the array, while a cycle runs
   task automatic waitDone();
      logic [7:0] q;
      q = 8'h01;
      for (int n = 0; n < 50 && q[0] !== 1'b0; n++) begin
         eps_cpu_model_inst.acc(1'b0, 16'hfe1d, 8'h00, q);
      end
      chk(q & 8'h01, 8'h00);
   endtask
   task automatic run(input logic [15:0] a, input logic [7:0] d, input logic [1:0] m);
      wr(16'hfe1d, {3'h0, m, 3'h6});
      wr(a, d);
      wr(16'hfe1d, {3'h0, m, 3'h7});
      waitDone();
      wr(16'hfe1d, 8'h00);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ************************
   // sequence
   // ************************
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      nvInit <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d);
         end else begin
            rd(rows[i].a, rows[i].d);
         end
      end
      wr(16'hfe1d, 8'h06);
      wr(16'hfe1d, 8'h07);
      rd(16'hfe1d, 8'h06);
      wr(16'h0805, 8'ha5);
      wr(16'h0806, 8'h3c);
      rd(16'h0806, 8'h3c);
      wr(16'hfe1d, 8'h07);
      waitDone();
      wr(16'hfe1d, 8'h00);
      rd(16'h0806, 8'h3c);
      rd(16'h0805, 8'hff);
      run(16'h0806, 8'hf0, 2'h0);
      rd(16'h0806, 8'h30);
      run(16'h0806, 8'h00, 2'h1);
      rd(16'h0806, 8'hff);
      wr(16'hfe1d, 8'h04);
      wr(16'h0810, 8'h00);
      wr(16'hfe1d, 8'h05);
      wr(16'hfe1d, 8'h01);
      rd(16'hfe1d, 8'h05);
      repeat (20) @(posedge clk);
      wr(16'hfe1d, 8'h00);
      rd(16'hfe1d, 8'h04);
      wr(16'hfe1d, 8'h00);
      rd(16'h0810, 8'h00);
      wr(16'hfe1d, 8'h06);
      wr(16'h0820, 8'h55);
      wr(16'hfe1d, 8'h07);
      stopMode <= 1'b1;
      repeat (20) @(posedge clk);
      stopMode <= 1'b0;
      waitDone();
      wr(16'hfe1d, 8'h00);
      rd(16'h0820, 8'h55);
      run(16'hfe1c, 8'h00, 2'h1);
      rd(16'hfe1f, 8'h10);
      rd(16'hfe1c, 8'hff);
      rd(16'hfe1f, 8'h1f);
      run(16'h0810, 8'h00, 2'h1);
      rd(16'h0810, 8'h00);
      run(16'hfe1c, 8'hee, 2'h0);
      rd(16'hfe1c, 8'hee);
      // a second reset loads the security and protect bits from the nv byte
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(16'hfe1f, 8'hee);
      run(16'h0810, 8'h00, 2'h1);
      rd(16'h0810, 8'hff);
      run(16'h0810, 8'h00, 2'h0);
      run(16'h0810, 8'h00, 2'h3);
      rd(16'h0810, 8'h00);
      run(16'hfe1c, 8'h00, 2'h1);
      rd(16'hfe1c, 8'hee);
      // half-rate crystal ticks: the bus clock would have ended the cycle by now
      timebaseClockSelect <= 1'b1;
      wr(16'hfe1d, 8'h06);
      wr(16'h0830, 8'h0f);
      wr(16'hfe1d, 8'h07);
      repeat (6) @(posedge clk);
      chk({7'h0, hvActive}, 8'h01);
      rd(16'hfe1d, 8'h07);
      waitDone();
      wr(16'hfe1d, 8'h00);
      chk({7'h0, hvActive}, 8'h00);
      rd(16'h0830, 8'h0f);
      summarize();
   end
   initial begin
      #2000000;
      errTotal++;
      summarize();
   end
endmodule
